// File: verilog/pwm_ctrl_defines.vh
// register map, field positions, reset values and prescaler counter settings for the pwm control block
`ifndef PWM_CTRL_DEFINES_VH
`define PWM_CTRL_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_PRESCALE_CLOCK_SELECT   4'h3
`define IDX_CENTER_ALIGN_ENABLE     4'h4
`define IDX_PAIRING_AND_STOP_CTRL   4'h5
// extra registers holding the channel enable, polarity and clock choice bits
`define IDX_CHANNEL_ENABLE          4'h0
`define IDX_CHANNEL_CLOCK_CHOICE    4'h2
`define IDX_CHANNEL_POLARITY        4'h1
// read-only status: prescaler run flag with clock a count, and effective pin enables
`define IDX_PRESCALE_STATUS         4'h6
`define IDX_EFFECTIVE_ENABLE        4'h7

// prescale register fields
`define CLKB_SEL_HI                 6
`define CLKB_SEL_LO                 4
`define CLKA_SEL_HI                 2
`define CLKA_SEL_LO                 0

// control register fields
`define JOIN_CH6_CH7_BIT            7
`define JOIN_CH4_CH5_BIT            6
`define JOIN_CH2_CH3_BIT            5
`define JOIN_CH0_CH1_BIT            4
`define WAIT_STOP_BIT               3
`define FREEZE_STOP_BIT             2

// reset value of all control registers
`define CTRL_RESET_VALUE            8'h00

// prescaler counter width: divide by up to 128
`define PRESCALE_CNT_WIDTH          7
`define PRESCALE_CNT_RESET          7'h00

`endif

// File: verilog/prescale_divider.v
// one power-of-two prescaler producing a one-cycle tick at bus clock / 2^sel
`timescale 1ns/1ps
`include "pwm_ctrl_defines.vh"

module prescale_divider (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       run,
	input  wire [2:0] sel,
	output reg        tick,
	output wire [6:0] count
);

	reg  [6:0] cnt;      // free running divider chain
	reg  [6:0] mask;     // low bits that must be all ones for the tick
	wire [6:0] next_cnt; // incremented count

	assign next_cnt = cnt + 7'h01;
	assign count    = cnt;

	// mask of the chosen division: 2^sel - 1
	always @* begin
		case (sel)
			3'h0:    mask = 7'h00;
			3'h1:    mask = 7'h01;
			3'h2:    mask = 7'h03;
			3'h3:    mask = 7'h07;
			3'h4:    mask = 7'h0f;
			3'h5:    mask = 7'h1f;
			3'h6:    mask = 7'h3f;
			default: mask = 7'h7f;
		endcase
	end

	// counter advances only while the input clock is allowed; new rate acts at once
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= `PRESCALE_CNT_RESET;
			tick <= 1'b0;
		end else if (run) begin
			cnt  <= next_cnt;
			tick <= ((cnt & mask) == mask);
		end else begin
			tick <= 1'b0;
		end
	end

endmodule

// File: verilog/channel_route.v
// per-channel routing of clock source, alignment, polarity and enable with pairing
`timescale 1ns/1ps
`include "pwm_ctrl_defines.vh"

module channel_route (
	input  wire [7:0] enable_bits,
	input  wire [7:0] clock_choice,
	input  wire [7:0] polarity_bits,
	input  wire [7:0] center_bits,
	input  wire [3:0] join_pairs,
	input  wire       tick_a,
	input  wire       tick_b,
	input  wire       tick_sa,
	input  wire       tick_sb,
	output wire [7:0] eff_enable,
	output wire [7:0] eff_tick,
	output wire [7:0] eff_center,
	output wire [7:0] eff_polarity,
	output wire [7:0] pin_enable
);

	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : ch
			// odd channel of each pair governs the joined pair
			localparam integer GOV = (g | 1);
			localparam integer PR  = g / 2;
			wire joined = join_pairs[PR];
			// channels 2,3,6,7 see only clock b family, others only clock a
			wire use_b  = (g & 2) != 0;
			wire plain  = use_b ? tick_b : tick_a;
			wire scaled = use_b ? tick_sb : tick_sa;
			wire choice = clock_choice[joined ? GOV : g];
			assign eff_tick[g]     = choice ? scaled : plain;
			assign eff_center[g]   = center_bits[joined ? GOV : g];
			assign eff_polarity[g] = polarity_bits[joined ? GOV : g];
			assign eff_enable[g]   = enable_bits[joined ? GOV : g];
			// even pin of a joined pair stays off whatever its enable says
			assign pin_enable[g]   = (joined && (g % 2 == 0)) ? 1'b0 : eff_enable[g];
		end
	endgenerate

endmodule

// File: verilog/pwm_prescale_align_concat_ctrl.v
// control part of the eight channel pwm: prescalers, alignment, pairing, stop options
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "pwm_ctrl_defines.vh"

module pwm_prescale_align_concat_ctrl (
	input  wire        SYS_CLK,
	input  wire        RESET_N,
	input  wire        WAIT_MODE,
	input  wire        FREEZE_MODE,
	input  wire        SCALED_CLOCK_FIRST,
	input  wire        SCALED_CLOCK_SECOND,
	input  wire        WB_CYC_I,
	input  wire        WB_STB_I,
	input  wire        WB_WE_I,
	input  wire [5:0]  WB_ADR_I,
	input  wire [3:0]  WB_SEL_I,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK_O,
	output wire        CLOCK_A_TICK,
	output wire        CLOCK_B_TICK,
	output wire [7:0]  CHANNEL_TICK,
	output wire [7:0]  CHANNEL_CENTER,
	output wire [7:0]  CHANNEL_POLARITY,
	output wire [7:0]  CHANNEL_ENABLE,
	output wire [7:0]  WAVEFORM_PIN_ENABLE,
	output wire [3:0]  JOIN_PAIRS
);

	// register map, one byte per word, data on byte lane 0:
	//   index 0: channel enable bits, one per channel
	//   index 1: channel polarity bits
	//   index 2: channel clock choice, plain or scaled
	//   index 3: prescale select, clock b in 6..4, clock a in 2..0
	//   index 4: center alignment bits, set means centered
	//   index 5: join bits 7..4, wait stop 3, freeze stop 2
	//   index 6: status, run flag over the clock a counter
	//   index 7: effective pin enables, read only
	//   higher indices read zero and ignore writes
	// bus timing:
	//   a request is taken on the edge where cyc and stb are high and ack low
	//   ack follows one cycle later and lasts one cycle
	//   write data lands on the taking edge
	//   read data is registered with the ack and holds until the next read
	//   the master drops stb for a cycle between transfers
	// prescalers:
	//   two dividers share one run signal
	//   each divider is a free running seven bit counter
	//   a tick marks the cycle after the selected low bits wrap
	//   a new select acts on the next cycle
	//   so one short or long period may follow a rate change
	//   code zero gives a tick on every cycle
	// stop options:
	//   wait and freeze come from the cpu clock logic, so they are synchronised
	//   run falls two cycles after the mode input rises with its stop bit set
	//   while run is low both counters hold; scaled ticks are forced low at once, clock a and b ticks from the next edge
	//   the scaled clock inputs are gated by the same run signal
	//   registers stay readable and writable while stopped
	// pairing:
	//   the odd channel of a joined pair governs clock, polarity, alignment, enable
	//   the even pin of a joined pair is forced off
	//   software should change join and alignment bits only with channels off
	//   the block does not enforce that; a glitch on the pin is the cost
	// reset:
	//   all software registers clear: full rate, left alignment, no pairs
	//   the release is synchronised so every flop leaves reset on one edge
	//   the first bus request is welcome on the third edge after release

	// reset release through two flip-flops
	reg        rst_meta;
	reg        rst_sync;
	// mode inputs synchronised
	reg        wait_meta;
	reg        wait_sync;
	reg        frz_meta;
	reg        frz_sync;
	// software registers
	reg  [7:0] prescale_clock_select;
	reg  [7:0] center_align_enable;
	reg  [7:0] pairing_and_stop_control;
	reg  [7:0] channel_enable_bit;
	reg  [7:0] channel_clock_choice;
	reg  [7:0] channel_polarity;
	// bus decode
	wire       bus_req;
	wire       wr_hit;
	wire [3:0] reg_idx;
	wire       addr_ok;
	reg  [7:0] rd_byte;
	// prescaler gating and ticks
	wire       wait_mode_clock_stop;
	wire       freeze_mode_clock_stop;
	wire       prescale_run;
	wire       tick_a;
	wire       tick_b;
	wire [6:0] cnt_a;

	// reset synchroniser
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// wait and freeze inputs come from outside, two flops each
	always @(posedge SYS_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			wait_meta <= 1'b0;
			wait_sync <= 1'b0;
			frz_meta  <= 1'b0;
			frz_sync  <= 1'b0;
		end else begin
			wait_meta <= WAIT_MODE;
			wait_sync <= wait_meta;
			frz_meta  <= FREEZE_MODE;
			frz_sync  <= frz_meta;
		end
	end

	// bus address decode: word index from byte address
	// a request counts only while ack is low, so a held request
	// is taken once per ack, and the cycle carrying the ack is never a new transfer
	// only byte lane 0 matters; other lane selects are ignored
	// the index is four bits, so byte addresses above 0x1f alias nothing
	assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign reg_idx = WB_ADR_I[5:2];
	assign addr_ok = (reg_idx <= `IDX_EFFECTIVE_ENABLE);
	assign wr_hit  = bus_req & WB_WE_I & WB_SEL_I[0];

	// register writes; byte lane 0 carries the data
	always @(posedge SYS_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			prescale_clock_select    <= `CTRL_RESET_VALUE;
			center_align_enable      <= `CTRL_RESET_VALUE;
			pairing_and_stop_control <= `CTRL_RESET_VALUE;
			channel_enable_bit       <= `CTRL_RESET_VALUE;
			channel_clock_choice     <= `CTRL_RESET_VALUE;
			channel_polarity         <= `CTRL_RESET_VALUE;
		end else if (wr_hit) begin
			// writes accepted anytime, no channel-state check
			case (reg_idx)
				`IDX_PRESCALE_CLOCK_SELECT: begin
					// bits 7 and 3 are unused and read zero
					prescale_clock_select <= WB_DAT_I[7:0] & 8'h77;
				end
				`IDX_CENTER_ALIGN_ENABLE: begin
					center_align_enable <= WB_DAT_I[7:0];
				end
				`IDX_PAIRING_AND_STOP_CTRL: begin
					// low two bits unused
					pairing_and_stop_control <= WB_DAT_I[7:0] & 8'hfc;
				end
				`IDX_CHANNEL_ENABLE: begin
					channel_enable_bit <= WB_DAT_I[7:0];
				end
				`IDX_CHANNEL_POLARITY: begin
					channel_polarity <= WB_DAT_I[7:0];
				end
				`IDX_CHANNEL_CLOCK_CHOICE: begin
					channel_clock_choice <= WB_DAT_I[7:0];
				end
				default: begin
					// read-only or unmapped: ignored
				end
			endcase
		end
	end

	// read mux
	always @* begin
		case (reg_idx)
			`IDX_PRESCALE_CLOCK_SELECT: rd_byte = prescale_clock_select;
			`IDX_CENTER_ALIGN_ENABLE:   rd_byte = center_align_enable;
			`IDX_PAIRING_AND_STOP_CTRL: rd_byte = pairing_and_stop_control;
			`IDX_CHANNEL_ENABLE:        rd_byte = channel_enable_bit;
			`IDX_CHANNEL_POLARITY:      rd_byte = channel_polarity;
			`IDX_CHANNEL_CLOCK_CHOICE:  rd_byte = channel_clock_choice;
			`IDX_PRESCALE_STATUS:       rd_byte = {prescale_run, cnt_a};
			`IDX_EFFECTIVE_ENABLE:      rd_byte = WAVEFORM_PIN_ENABLE;
			default:                    rd_byte = 8'h00;
		endcase
	end

	// bus answer: ack one cycle after the request, unmapped reads zero
	// ack is a flop, so the slave answers with exactly one wait state
	// read data is captured on the taking edge and shown with the ack
	// writes leave the read data untouched
	// upper three bytes always read zero
	always @(posedge SYS_CLK or negedge rst_sync) begin
		if (!rst_sync) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= bus_req;
			if (bus_req && !WB_WE_I) begin
				WB_DAT_O <= {24'h00_0000, (addr_ok ? rd_byte : 8'h00)};
			end
		end
	end

	// prescaler input clock gating in wait and freeze modes
	// either mode alone stops the prescalers when its own stop bit is set
	// clearing the bit or leaving the mode restarts counting where it held
	// counters are not cleared by a stop, so timing resumes in phase
	assign wait_mode_clock_stop   = pairing_and_stop_control[`WAIT_STOP_BIT];
	assign freeze_mode_clock_stop = pairing_and_stop_control[`FREEZE_STOP_BIT];
	assign prescale_run = ~(wait_mode_clock_stop & wait_sync)
	                    & ~(freeze_mode_clock_stop & frz_sync);

	// clock a prescaler
	// its counter is also shown in the status register for software
	prescale_divider u_div_a (
		.clk   (SYS_CLK),
		.rst_n (rst_sync),
		.run   (prescale_run),
		.sel   (prescale_clock_select[`CLKA_SEL_HI:`CLKA_SEL_LO]),
		.tick  (tick_a),
		.count (cnt_a)
	);

	// clock b prescaler
	// its counter is not shown anywhere, so the count output is left open
	prescale_divider u_div_b (
		.clk   (SYS_CLK),
		.rst_n (rst_sync),
		.run   (prescale_run),
		.sel   (prescale_clock_select[`CLKB_SEL_HI:`CLKB_SEL_LO]),
		.tick  (tick_b),
		.count ()
	);

	// both ticks leave the block for the channel counters and scalers
	// they are one cycle pulses, high for one bus clock per period

	assign CLOCK_A_TICK = tick_a;
	assign CLOCK_B_TICK = tick_b;
	// join bits in pair order 0/1, 2/3, 4/5, 6/7
	assign JOIN_PAIRS = {pairing_and_stop_control[`JOIN_CH6_CH7_BIT],
	                     pairing_and_stop_control[`JOIN_CH4_CH5_BIT],
	                     pairing_and_stop_control[`JOIN_CH2_CH3_BIT],
	                     pairing_and_stop_control[`JOIN_CH0_CH1_BIT]};

	// per-channel routing
	// channels 0, 1, 4, 5 draw from clock a or the first scaled clock
	// channels 2, 3, 6, 7 draw from clock b or the second scaled clock
	// each clock choice bit picks plain or scaled for its channel
	// a joined pair takes every setting from its odd channel
	// the even pin of a joined pair is held off whatever its enable says
	// all of this is combinational on registered settings, prescaler ticks and the scaled clock inputs
	// the scaled ticks are gated by run so a stop silences them too
	// polarity and alignment are passed on unchanged when not joined
	// the pin enables also feed the read-only status word
	channel_route u_route (
		.enable_bits   (channel_enable_bit),
		.clock_choice  (channel_clock_choice),
		.polarity_bits (channel_polarity),
		.center_bits   (center_align_enable),
		.join_pairs    (JOIN_PAIRS),
		.tick_a        (tick_a),
		.tick_b        (tick_b),
		.tick_sa       (SCALED_CLOCK_FIRST & prescale_run),
		.tick_sb       (SCALED_CLOCK_SECOND & prescale_run),
		.eff_enable    (CHANNEL_ENABLE),
		.eff_tick      (CHANNEL_TICK),
		.eff_center    (CHANNEL_CENTER),
		.eff_polarity  (CHANNEL_POLARITY),
		.pin_enable    (WAVEFORM_PIN_ENABLE)
	);

endmodule

// File: bench/pwm_ctrl_monitor.sv
// checker for bus timing, clock routing, pin pairing and stop gating
`timescale 1ns/1ps
module pwm_ctrl_monitor (
	input wire        SYS_CLK,
	input wire        RESET_N,
	input wire        WAIT_MODE,
	input wire        FREEZE_MODE,
	input wire        SCALED_CLOCK_FIRST,
	input wire        SCALED_CLOCK_SECOND,
	input wire        WB_CYC_I,
	input wire        WB_STB_I,
	input wire        WB_WE_I,
	input wire [5:0]  WB_ADR_I,
	input wire [3:0]  WB_SEL_I,
	input wire [31:0] WB_DAT_I,
	input wire        WB_ACK_O,
	input wire        CLOCK_A_TICK,
	input wire        CLOCK_B_TICK,
	input wire [7:0]  CHANNEL_TICK,
	input wire [7:0]  WAVEFORM_PIN_ENABLE,
	input wire [3:0]  JOIN_PAIRS
);
	reg [7:0] ctl; // shadow of the pairing and stop byte
	// follow control writes at the edge that takes them
	always @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N)
			ctl <= 8'h00;
		else if (WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0]
			&& WB_ADR_I[5:2] == 4'h5)
			ctl <= WB_DAT_I[7:0];
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);
	property p_ack_resp; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack not one cycle after request");
	property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause; $rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_pin_join; (JOIN_PAIRS & {WAVEFORM_PIN_ENABLE[6], WAVEFORM_PIN_ENABLE[4],
		WAVEFORM_PIN_ENABLE[2], WAVEFORM_PIN_ENABLE[0]}) == 4'h0; endproperty
	a_pin_join: assert property (p_pin_join) else $error("even pin on while joined");
	property p_tick_a; |(CHANNEL_TICK & 8'h33) |-> CLOCK_A_TICK || SCALED_CLOCK_FIRST; endproperty
	a_tick_a: assert property (p_tick_a) else $error("a channel ticked without clock a");
	property p_tick_b; |(CHANNEL_TICK & 8'hcc) |-> CLOCK_B_TICK || SCALED_CLOCK_SECOND; endproperty
	a_tick_b: assert property (p_tick_b) else $error("b channel ticked without clock b");
	property p_wait_stop; (ctl[3] && WAIT_MODE) [*5] |-> !CLOCK_A_TICK && !CLOCK_B_TICK
		&& CHANNEL_TICK == 8'h00; endproperty
	a_wait_stop: assert property (p_wait_stop) else $error("ticks during wait stop");
	property p_frz_stop; (ctl[2] && FREEZE_MODE) [*5] |-> !CLOCK_A_TICK && !CLOCK_B_TICK
		&& CHANNEL_TICK == 8'h00; endproperty
	a_frz_stop: assert property (p_frz_stop) else $error("ticks during freeze stop");
endmodule

// File: bench/pwm_prescale_align_concat_ctrl_test.sv
// self-checking bench for the pwm control block
`timescale 1ns/1ps
module pwm_prescale_align_concat_ctrl_test;
	logic SYS_CLK, RESET_N, WAIT_MODE, FREEZE_MODE, SCALED_CLOCK_FIRST, SCALED_CLOCK_SECOND;
	logic WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, CLOCK_A_TICK, CLOCK_B_TICK;
	logic [5:0]  WB_ADR_I;
	logic [3:0]  WB_SEL_I, JOIN_PAIRS;
	logic [31:0] WB_DAT_I, WB_DAT_O;
	logic [7:0]  CHANNEL_TICK, CHANNEL_CENTER, CHANNEL_POLARITY, CHANNEL_ENABLE;
	logic [7:0]  WAVEFORM_PIN_ENABLE, q;
	int          err_total, check_count, p;
	pwm_prescale_align_concat_ctrl pwm_prescale_align_concat_ctrl_i (.*);
	initial begin
		SYS_CLK = 1'h0;
		forever #20 SYS_CLK = ~SYS_CLK;
	end
	task chk(input string nm, input [31:0] s, input [31:0] e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	// one classic cycle, held until ack is sampled
	task wb(input w, input [3:0] i, input [7:0] d);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'h3, w, i, 2'h0, 24'h0, d};
		do begin
			@(posedge SYS_CLK);
			n++;
		end while (WB_ACK_O !== 1'h1 && n < 20);
		q = WB_DAT_O[7:0];
		{WB_CYC_I, WB_STB_I, WB_WE_I} <= 3'h0;
		if (n == 20) chk("ack", 0, 1);
	endtask
	task rd(input [3:0] i, input [7:0] e, input string nm);
		wb(1'h0, i, 8'h00);
		chk(nm, q, e);
	endtask
	// cycles until the next tick of clock a or b
	task wt(input b);
		p = 0;
		do begin
			@(posedge SYS_CLK);
			p++;
		end while ((b ? CLOCK_B_TICK : CLOCK_A_TICK) !== 1'h1 && p < 300);
	endtask
	task t_reset;
		rd(4'h3, 8'h00, "prescale reset");
		rd(4'h4, 8'h00, "center reset");
		rd(4'h5, 8'h00, "control reset");
		rd(4'h8, 8'h00, "unmapped read");
		$display("reset test done");
	endtask
	task t_rates;
		for (int n = 0; n < 8; n++) begin
			wb(1'h1, 4'h3, {1'h0, n[2:0], 1'h0, n[2:0]});
			repeat (3) wt(1'h0);
			chk("clock a period", p, 1 << n);
			repeat (3) wt(1'h1);
			chk("clock b period", p, 1 << n);
		end
		wb(1'h1, 4'h3, 8'h00);
		wt(1'h0);
		chk("rate change at once", p <= 2, 1);
		wb(1'h1, 4'h3, 8'hff);
		rd(4'h3, 8'h77, "prescale fields");
		$display("rates test done");
	endtask
	task t_align;
		wb(1'h1, 4'h0, 8'h00);
		wb(1'h1, 4'h4, 8'ha5);
		@(negedge SYS_CLK);
		chk("center bits", CHANNEL_CENTER, 8'ha5);
		rd(4'h4, 8'ha5, "center readback");
		wb(1'h1, 4'h4, 8'h00);
		$display("align test done");
	endtask
	task t_join;
		for (int k = 0; k < 4; k++) begin
			wb(1'h1, 4'h0, 8'h00);
			wb(1'h1, 4'h5, (8'h10 << k) | 8'h03);
			rd(4'h5, 8'h10 << k, "join readback");
			wb(1'h1, 4'h0, 8'hff);
			@(negedge SYS_CLK);
			chk("join pairs", JOIN_PAIRS, 4'h1 << k);
			chk("even pin off", WAVEFORM_PIN_ENABLE, 8'hff ^ (8'h01 << 2 * k));
			wb(1'h1, 4'h0, 8'hff ^ (8'h02 << 2 * k));
			@(negedge SYS_CLK);
			chk("odd governs pin", WAVEFORM_PIN_ENABLE, 8'hff ^ (8'h03 << 2 * k));
			chk("odd enable", CHANNEL_ENABLE[2 * k + 1], 0);
			rd(4'h7, 8'hff ^ (8'h03 << 2 * k), "pin enable status");
			wb(1'h1, 4'h1, 8'h02 << 2 * k);
			@(negedge SYS_CLK);
			chk("even follows odd polarity", CHANNEL_POLARITY[2 * k], 1);
		end
		wb(1'h1, 4'h1, 8'h00);
		wb(1'h1, 4'h0, 8'h00);
		wb(1'h1, 4'h5, 8'h00);
		$display("join test done");
	endtask
	task t_choice;
		wb(1'h1, 4'h3, 8'h77);
		wb(1'h1, 4'h2, 8'h05);
		@(posedge SYS_CLK);
		{SCALED_CLOCK_FIRST, SCALED_CLOCK_SECOND} <= 2'h2;
		@(negedge SYS_CLK);
		chk("scaled a route", CHANNEL_TICK & 8'h05, 8'h01);
		@(posedge SYS_CLK);
		{SCALED_CLOCK_FIRST, SCALED_CLOCK_SECOND} <= 2'h1;
		@(negedge SYS_CLK);
		chk("scaled b route", CHANNEL_TICK & 8'h05, 8'h04);
		@(posedge SYS_CLK);
		{SCALED_CLOCK_FIRST, SCALED_CLOCK_SECOND} <= 2'h0;
		wb(1'h1, 4'h2, 8'h00);
		$display("clock choice test done");
	endtask
	// set a stop option and a cpu mode, then count clock a ticks at full rate
	task stop(input [7:0] c, input [1:0] m, input int e);
		int n;
		n = 0;
		wb(1'h1, 4'h5, c);
		{WAIT_MODE, FREEZE_MODE} <= m;
		repeat (6) @(posedge SYS_CLK);
		repeat (16) begin
			@(posedge SYS_CLK);
			if (CLOCK_A_TICK === 1'h1) n++;
		end
		rd(4'h5, c, "control in mode");
		chk("ticks in mode", n, e);
		{WAIT_MODE, FREEZE_MODE} <= 2'h0;
	endtask
	task t_stop;
		wb(1'h1, 4'h3, 8'h00);
		stop(8'h08, 2'h2, 0);
		stop(8'h00, 2'h2, 16);
		stop(8'h04, 2'h1, 0);
		stop(8'h08, 2'h1, 16);
		stop(8'h04, 2'h0, 16);
		$display("stop test done");
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		{RESET_N, WAIT_MODE, FREEZE_MODE, SCALED_CLOCK_FIRST, SCALED_CLOCK_SECOND} <= 5'h00;
		{WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, WB_SEL_I} <= {41'h0, 4'hf};
		err_total = 0;
		check_count = 0;
		repeat (10) @(posedge SYS_CLK);
		RESET_N <= 1'h1;
		repeat (4) @(posedge SYS_CLK);
		t_reset;
		t_rates;
		t_align;
		t_join;
		t_choice;
		t_stop;
		complete_run;
	end
	initial begin
		#2000000;
		err_total++;
		complete_run;
	end
endmodule
bind pwm_prescale_align_concat_ctrl pwm_ctrl_monitor pwm_ctrl_monitor_i (.*);
